// File: spm_pkg.sv
package spm_pkg;

	// ----------------------------------------------------------------
	// register byte offsets inside the power block
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_FIXED_LAT  = 12'h078;
	localparam logic [11:0] ADDR_ECO_SLEEP  = 12'h07c;
	localparam logic [11:0] ADDR_WARN_EVT   = 12'h108;
	localparam logic [11:0] ADDR_CAUSE      = 12'h400;
	localparam logic [11:0] ADDR_RAM_STAT   = 12'h428;
	localparam logic [11:0] ADDR_SYS_OFF    = 12'h500;
	localparam logic [11:0] ADDR_WARN_CFG   = 12'h510;
	localparam logic [11:0] ADDR_GP_RET     = 12'h51c;
	localparam logic [11:0] ADDR_RAM_CTRL   = 12'h524;
	localparam logic [11:0] ADDR_RST_CFG    = 12'h544;
	localparam logic [11:0] ADDR_RAM_CTRL_U = 12'h554;
	localparam logic [11:0] ADDR_BUCK       = 12'h578;
	localparam logic [11:0] ADDR_MODE_STAT  = 12'h600;
	localparam logic [11:0] ADDR_WORD_MASK  = 12'hffc;
	localparam logic [2:0]  HSIZE_WORD      = 3'h2;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CAUSE_PIN  = 0;
	localparam int CAUSE_DOG  = 1;
	localparam int CAUSE_SREQ = 2;
	localparam int CAUSE_LOCK = 3;
	localparam int CAUSE_GPIO = 16;
	localparam int CAUSE_COMP = 17;
	localparam int CAUSE_DBG  = 18;
	localparam logic [31:0] CAUSE_MASK = 32'h0007000f;
	localparam int RAM_ON_LSB   = 0;
	localparam int RAM_RET_LSB  = 16;
	localparam int BLK_PER_REG  = 2;
	localparam logic [31:0] RAM_CTRL_RST = 32'h00000003;
	localparam int WCFG_EN      = 0;
	localparam int WCFG_THR_LSB = 1;
	localparam int MODE_LAT     = 4;
	localparam int MODE_WARN    = 5;
	localparam int MODE_DBG     = 6;
	localparam int GP_RET_W     = 8;
	localparam int IN_GPIO = 0;
	localparam int IN_COMP = 1;
	localparam int IN_PINN = 2;
	localparam int IN_DBG  = 3;
	localparam logic [3:0] FILT_RST = 4'h4;

	// ----------------------------------------------------------------
	// supply levels, units of 10 mV
	// ----------------------------------------------------------------
	localparam int SUP_W = 9;
	localparam logic [SUP_W-1:0] FAIL_LVL [4] = '{9'h0d2, 9'h0e6, 9'h0fa, 9'h10e};
	localparam logic [SUP_W-1:0] HYST_LVL = 9'h005;
	localparam logic [SUP_W-1:0] BOR_LVL  = 9'h0b4;
	localparam logic [SUP_W-1:0] MIN_LVL  = 9'h0be;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int RESET_TIME_NS = 400;
	localparam int RESET_CYCLES  = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCW = $clog2(RESET_CYCLES + 1);
	localparam logic [RCW-1:0] RCNT_LOAD = RCW'(RESET_CYCLES);

	typedef enum logic [3:0] {
		ST_ON  = 4'b0001,
		ST_OFF = 4'b0010,
		ST_EMU = 4'b0100,
		ST_RST = 4'b1000
	} spm_state_t;

endpackage : spm_pkg

// File: spm_power_reset_manager.sv
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps

module spm_power_reset_manager
	import spm_pkg::*;
#(
	parameter int NBLK = 4,
	parameter int NIRQ = 32
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic [31:0]           hrdata,
	output logic                  hresp,
	input  wire logic             gpioDetect,
	input  wire logic             analogWakeDetect,
	input  wire logic             resetPinN,
	input  wire logic             debugIfActive,
	input  wire logic             watchdogTimeout,
	input  wire logic             cpuLockup,
	input  wire logic             coreSystemResetRequest,
	input  wire logic [SUP_W-1:0] supplyLevel,
	input  wire logic             radioEnabled,
	input  wire logic             waitIntSleep,
	input  wire logic             waitEventSleep,
	input  wire logic [NIRQ-1:0]  irqPending,
	input  wire logic [NIRQ-1:0]  irqEnabled,
	output logic                  sysReset,
	output logic                  debugPortReset,
	output logic                  coreDomainOn,
	output logic                  debugDomainsOn,
	output logic                  peripheralsOn,
	output logic                  taskAbort,
	output logic [NBLK-1:0]       ramPower,
	output logic                  buckConverterOn,
	output logic                  forcedBaseOn,
	output logic                  cpuWake,
	output logic                  powerWarn,
	output logic                  flashWriteBlock
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		spm_state_t          st;
		logic [RCW-1:0]      rcnt;
		logic                keepDap;
		logic [3:0]          s1;
		logic [3:0]          s2;
		logic [3:0]          s3;
		logic [3:0]          filt;
		logic                fixed_latency_task;
		logic                buckArm;
		logic                bk;
		logic                fbo;
		logic                wk;
		logic                pofEn;
		logic [1:0]          thr;
		logic                warn;
		logic                warnEvt;
		logic [31:0]         cause;
		logic [31:0]         ramCtrl;
		logic [31:0]         ramCtrlUp;
		logic [GP_RET_W-1:0] gpRet;
		logic                pinRstEn;
		logic [NBLK-1:0]     ramPwr;
		logic                dPhase;
		logic                dWrite;
		logic [11:0]         dAddr;
		logic [31:0]         rdata;
	} spm_regs_t;

	spm_regs_t        q;
	spm_regs_t        n;
	logic [NBLK-1:0]  retBits;
	logic [NBLK-1:0]  onBits;
	logic [NBLK-1:0]  ramPwrNxt;
	logic             wr;
	logic             take;
	logic             dbg;
	logic             pinAct;
	logic             offReq;
	logic [31:0]      sets;
	logic [31:0]      clr;
	logic [SUP_W-1:0] failLvl;
	logic [SUP_W:0]   clearLvl;

	// ----------------------------------------------------------------
	// per-block ram power
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NBLK; g++) begin : g_ram
		localparam int bitSel = g % BLK_PER_REG;
		logic [31:0] ctl;
		// blocks above the first pair are steered by the upper control word
		assign ctl          = (g < BLK_PER_REG) ? q.ramCtrl : q.ramCtrlUp;
		assign retBits[g]   = ctl[RAM_RET_LSB + bitSel];
		assign onBits[g]    = ctl[RAM_ON_LSB + bitSel];
		assign ramPwrNxt[g] = (q.st == ST_OFF) ? retBits[g] : onBits[g];
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		n        = q;
		sets     = '0;
		clr      = '0;
		offReq   = 1'b0;
		wr       = q.dPhase & q.dWrite;
		take     = hsel & htrans[1] & hready;
		dbg      = q.filt[IN_DBG];
		pinAct   = ~q.filt[IN_PINN] & (~dbg | q.pinRstEn);
		failLvl  = FAIL_LVL[q.thr];
		clearLvl = {1'b0, failLvl} + {1'b0, HYST_LVL};

		// pin synchroniser: a change counts once stages two and three agree
		n.s1   = {debugIfActive, resetPinN, analogWakeDetect, gpioDetect};
		n.s2   = q.s1;
		n.s3   = q.s2;
		n.filt = (q.s3 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));

		// bus address phase; read data is captured here so it is ready in the data phase
		n.dPhase = take;
		n.dWrite = hwrite & (hsize == HSIZE_WORD);
		n.dAddr  = haddr[11:0] & ADDR_WORD_MASK;
		if (take && !hwrite) begin
			case (haddr[11:0] & ADDR_WORD_MASK)
				ADDR_WARN_EVT:   n.rdata = 32'(q.warnEvt);
				ADDR_CAUSE:      n.rdata = q.cause;
				ADDR_RAM_STAT:   n.rdata = 32'(q.ramPwr);
				ADDR_WARN_CFG:   n.rdata = 32'(q.pofEn) | (32'(q.thr) << WCFG_THR_LSB);
				ADDR_GP_RET:     n.rdata = 32'(q.gpRet);
				ADDR_RAM_CTRL:   n.rdata = q.ramCtrl;
				ADDR_RST_CFG:    n.rdata = 32'(q.pinRstEn);
				ADDR_RAM_CTRL_U: n.rdata = q.ramCtrlUp;
				ADDR_BUCK:       n.rdata = 32'(q.buckArm);
				ADDR_MODE_STAT:  n.rdata = 32'(q.st) | (32'(q.fixed_latency_task) << MODE_LAT)
					| (32'(q.warn) << MODE_WARN) | (32'(dbg) << MODE_DBG);
				default:         n.rdata = '0;
			endcase
		end

		// bus data phase writes; unmapped offsets are ignored
		if (wr) begin
			case (q.dAddr)
				ADDR_FIXED_LAT: if (hwdata[0]) n.fixed_latency_task = 1'b1;
				ADDR_ECO_SLEEP: if (hwdata[0]) n.fixed_latency_task = 1'b0;
				ADDR_WARN_EVT:  if (!hwdata[0]) n.warnEvt = 1'b0;
				ADDR_CAUSE:     clr = hwdata & CAUSE_MASK;
				ADDR_SYS_OFF:   offReq = hwdata[0];
				ADDR_WARN_CFG: begin
					n.pofEn = hwdata[WCFG_EN];
					n.thr   = hwdata[WCFG_THR_LSB +: 2];
				end
				ADDR_GP_RET:     n.gpRet = hwdata[GP_RET_W-1:0];
				ADDR_RAM_CTRL:   n.ramCtrl = hwdata;
				ADDR_RST_CFG:    n.pinRstEn = hwdata[0];
				ADDR_RAM_CTRL_U: n.ramCtrlUp = hwdata;
				ADDR_BUCK:       n.buckArm = hwdata[0];
				default:         ;
			endcase
		end

		// power-fail comparator with hysteresis; it never resets anything
		if (!q.pofEn)
			n.warn = 1'b0;
		else if (!q.warn && supplyLevel < failLvl)
			n.warn = 1'b1;
		else if (q.warn && {1'b0, supplyLevel} >= clearLvl)
			n.warn = 1'b0;
		// set after the clear above so a warning in the clear cycle is kept
		if (n.warn && !q.warn)
			n.warnEvt = 1'b1;

		// sleep wake and latency resources
		n.wk  = (waitIntSleep & |(irqPending & irqEnabled))
			| (waitEventSleep & |irqPending);
		n.fbo = q.fixed_latency_task & (waitIntSleep | waitEventSleep);
		// converter only runs while the radio needs it, saving idle power
		n.bk  = q.buckArm & radioEnabled;
		n.ramPwr = ramPwrNxt;

		// power mode sequencing
		unique case (q.st)
			ST_RST: begin
				n.fixed_latency_task = 1'b0;
				if (supplyLevel < MIN_LVL)
					n.rcnt = RCNT_LOAD;
				else if (q.rcnt == '0) begin
					n.st      = ST_ON;
					n.keepDap = 1'b0;
				end else
					n.rcnt = q.rcnt - 1'b1;
			end
			ST_ON: begin
				sets[CAUSE_PIN]  = pinAct;
				sets[CAUSE_DOG]  = watchdogTimeout;
				sets[CAUSE_SREQ] = coreSystemResetRequest;
				sets[CAUSE_LOCK] = cpuLockup & ~dbg;
				if (|sets) begin
					n.st      = ST_RST;
					n.rcnt    = RCNT_LOAD;
					n.keepDap = ~(pinAct | watchdogTimeout);
				end else if (offReq)
					n.st = dbg ? ST_EMU : ST_OFF;
			end
			ST_OFF, ST_EMU: begin
				sets[CAUSE_PIN]  = pinAct;
				sets[CAUSE_GPIO] = q.filt[IN_GPIO];
				sets[CAUSE_COMP] = q.filt[IN_COMP];
				sets[CAUSE_DBG]  = dbg & (q.st == ST_OFF);
				if (|sets) begin
					n.st      = ST_RST;
					n.rcnt    = RCNT_LOAD;
					n.keepDap = dbg & ~pinAct;
				end
			end
			default: begin
				n.st   = ST_RST;
				n.rcnt = RCNT_LOAD;
			end
		endcase

		// flags accumulate; a source in the clear cycle wins over the clear
		n.cause = (q.cause & ~clr) | sets;

		// brown-out overrides the power mode sequencing and leaves no cause flagged
		if (supplyLevel < BOR_LVL) begin
			n.st      = ST_RST;
			n.rcnt    = RCNT_LOAD;
			n.cause   = '0;
			n.keepDap = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers; ram control is only set back to RAM_CTRL_RST by the block's own power-on
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q           <= '0;
			q.st        <= ST_RST;
			q.rcnt      <= RCNT_LOAD;
			q.s1        <= FILT_RST;
			q.s2        <= FILT_RST;
			q.s3        <= FILT_RST;
			q.filt      <= FILT_RST;
			q.ramCtrl   <= RAM_CTRL_RST;
			q.ramCtrlUp <= RAM_CTRL_RST;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign hrdata          = q.rdata;
	assign sysReset        = q.st == ST_RST;
	assign debugPortReset  = sysReset & ~q.keepDap;
	assign coreDomainOn    = q.st != ST_OFF;
	assign debugDomainsOn  = q.st != ST_OFF;
	assign peripheralsOn   = q.st == ST_ON;
	assign taskAbort       = (q.st == ST_OFF) | (q.st == ST_EMU);
	assign ramPower        = q.ramPwr;
	assign buckConverterOn = q.bk;
	assign forcedBaseOn    = q.fbo;
	assign cpuWake         = q.wk;
	assign powerWarn       = q.warn;
	assign flashWriteBlock = q.warn;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_buck;
		!radioEnabled |=> !buckConverterOn;
	endproperty
	a_buck: assert property (p_buck) else $error("buck on without radio");

	// checked from the request onwards, not from the state register the outputs decode
	property p_off;
		wr && q.dAddr == ADDR_SYS_OFF && hwdata[0] && q.st == ST_ON && !dbg && !(|sets)
			&& supplyLevel >= BOR_LVL |=> taskAbort && !coreDomainOn && !peripheralsOn;
	endproperty
	a_off: assert property (p_off) else $error("core alive in off");

	property p_ret;
		q.st == ST_OFF && $stable(retBits) |=> ramPower == $past(retBits);
	endproperty
	a_ret: assert property (p_ret) else $error("ram power differs from retention");

	property p_gpio_wake;
		q.st == ST_OFF && q.filt[IN_GPIO] && supplyLevel >= BOR_LVL
			|=> sysReset && q.cause[CAUSE_GPIO];
	endproperty
	a_gpio_wake: assert property (p_gpio_wake) else $error("gpio wake missed");

	property p_emu;
		wr && q.dAddr == ADDR_SYS_OFF && hwdata[0] && q.st == ST_ON && dbg && !(|sets)
			&& supplyLevel >= BOR_LVL |=> q.st == ST_EMU && debugDomainsOn && coreDomainOn;
	endproperty
	a_emu: assert property (p_emu) else $error("debug domains off in emulation");

	property p_wfi;
		waitIntSleep && !waitEventSleep && !(|(irqPending & irqEnabled)) |=> !cpuWake;
	endproperty
	a_wfi: assert property (p_wfi) else $error("wake on disabled irq");

	property p_fixed;
		wr && q.dAddr == ADDR_FIXED_LAT && hwdata[0] && q.st == ST_ON
			&& supplyLevel >= BOR_LVL |=> q.fixed_latency_task;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed latency not taken");

	property p_default_low;
		sysReset ##1 q.st == ST_ON |-> !q.fixed_latency_task;
	endproperty
	a_default_low: assert property (p_default_low) else $error("sleep mode not low power");

	property p_warn;
		q.pofEn && q.warn == 1'b0 && supplyLevel < failLvl |=> powerWarn ##0 flashWriteBlock;
	endproperty
	a_warn: assert property (p_warn) else $error("power warning late");

	property p_por_hold;
		sysReset && supplyLevel < MIN_LVL |=> sysReset [*2];
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("reset released at low supply");

	property p_sreq;
		q.st == ST_ON && coreSystemResetRequest && supplyLevel >= BOR_LVL
			|=> sysReset && q.cause[CAUSE_SREQ] && !debugPortReset;
	endproperty
	a_sreq: assert property (p_sreq) else $error("soft reset missed");

	property p_cause_hold;
		q.cause[CAUSE_PIN] && !(wr && q.dAddr == ADDR_CAUSE && hwdata[CAUSE_PIN])
			&& supplyLevel >= BOR_LVL |=> q.cause[CAUSE_PIN];
	endproperty
	a_cause_hold: assert property (p_cause_hold) else $error("cause flag lost");

	c_emulated: cover property (q.st == ST_ON ##1 q.st == ST_EMU);
	c_wake_comp: cover property (q.st == ST_OFF ##1 sysReset && q.cause[CAUSE_COMP]);
	c_warn: cover property (!powerWarn ##1 powerWarn);

endmodule : spm_power_reset_manager

// File: spm_wake_source_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// wake and reset sources, cpu sleep lines and supply of the device
// ----------------------------------------------------------------
module spm_wake_source_model
	import spm_pkg::*;
#(
	parameter int NIRQ = 32
) (
	input  wire logic             mclk,
	output logic                  gpioDetect,
	output logic                  analogWakeDetect,
	output logic                  resetPinN,
	output logic                  debugIfActive,
	output logic                  watchdogTimeout,
	output logic                  cpuLockup,
	output logic                  coreSystemResetRequest,
	output logic [SUP_W-1:0]      supplyLevel,
	output logic                  radioEnabled,
	output logic                  waitIntSleep,
	output logic                  waitEventSleep,
	output logic [NIRQ-1:0]       irqPending,
	output logic [NIRQ-1:0]       irqEnabled
);
	// idle levels: reset pin pulled up, supply above brown-out but under minimum
	initial begin
		gpioDetect = 1'b0;
		analogWakeDetect = 1'b0;
		resetPinN = 1'b1;
		debugIfActive = 1'b0;
		watchdogTimeout = 1'b0;
		cpuLockup = 1'b0;
		coreSystemResetRequest = 1'b0;
		supplyLevel = 9'h0b8;
		radioEnabled = 1'b0;
		waitIntSleep = 1'b0;
		waitEventSleep = 1'b0;
		irqPending = '0;
		irqEnabled = '0;
	end

	// level lines of the pin side; idx 2 is the active low reset pin
	task setLine(input int idx, input logic v);
		@(posedge mclk);
		case (idx)
			0: gpioDetect <= v;
			1: analogWakeDetect <= v;
			2: resetPinN <= ~v;
			default: debugIfActive <= v;
		endcase
	endtask : setLine

	// one-cycle requests: a held request would trigger again after the reset
	task pulseReq(input int idx);
		@(posedge mclk);
		watchdogTimeout <= (idx == 0);
		cpuLockup <= (idx == 1);
		coreSystemResetRequest <= (idx == 2);
		@(posedge mclk);
		watchdogTimeout <= 1'b0;
		cpuLockup <= 1'b0;
		coreSystemResetRequest <= 1'b0;
	endtask : pulseReq

	// cpu sleep style, interrupt lines and radio activity
	task setCpu(input logic wi, input logic we, input logic [NIRQ-1:0] p,
		input logic [NIRQ-1:0] e, input logic radio);
		@(posedge mclk);
		waitIntSleep <= wi;
		waitEventSleep <= we;
		irqPending <= p;
		irqEnabled <= e;
		radioEnabled <= radio; // radio kept idle around system off requests
	endtask : setCpu

	task setSupply(input logic [SUP_W-1:0] v);
		@(posedge mclk);
		supplyLevel <= v;
	endtask : setSupply
endmodule : spm_wake_source_model

// File: spm_power_reset_manager_tb.sv
`timescale 1ns/1ps

`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
	$display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module spm_power_reset_manager_tb;
	import spm_pkg::*;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] hwdata = '0;
	logic hreadyout, hresp, gpioDetect, analogWakeDetect, resetPinN, debugIfActive;
	logic watchdogTimeout, cpuLockup, coreSystemResetRequest, radioEnabled;
	logic waitIntSleep, waitEventSleep, sysReset, debugPortReset, coreDomainOn;
	logic debugDomainsOn, peripheralsOn, taskAbort, buckConverterOn, forcedBaseOn;
	logic cpuWake, powerWarn, flashWriteBlock;
	logic [31:0] hrdata, irqPending, irqEnabled, expC;
	logic [SUP_W-1:0] supplyLevel;
	logic [3:0] ramPower;
	int errTotal = 0;
	int nCompared = 0;
	int cycles = 0;
	int cb [3] = '{CAUSE_DOG, CAUSE_LOCK, CAUSE_SREQ};

	always #12.5 mclk = ~mclk;

	spm_power_reset_manager i_spm_power_reset_manager (
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.gpioDetect(gpioDetect), .analogWakeDetect(analogWakeDetect),
		.resetPinN(resetPinN), .debugIfActive(debugIfActive),
		.watchdogTimeout(watchdogTimeout), .cpuLockup(cpuLockup),
		.coreSystemResetRequest(coreSystemResetRequest), .supplyLevel(supplyLevel),
		.radioEnabled(radioEnabled), .waitIntSleep(waitIntSleep),
		.waitEventSleep(waitEventSleep), .irqPending(irqPending),
		.irqEnabled(irqEnabled), .sysReset(sysReset), .debugPortReset(debugPortReset),
		.coreDomainOn(coreDomainOn), .debugDomainsOn(debugDomainsOn),
		.peripheralsOn(peripheralsOn), .taskAbort(taskAbort), .ramPower(ramPower),
		.buckConverterOn(buckConverterOn), .forcedBaseOn(forcedBaseOn),
		.cpuWake(cpuWake), .powerWarn(powerWarn), .flashWriteBlock(flashWriteBlock)
	);

	spm_wake_source_model i_spm_wake_source_model (
		.mclk(mclk), .gpioDetect(gpioDetect), .analogWakeDetect(analogWakeDetect),
		.resetPinN(resetPinN), .debugIfActive(debugIfActive),
		.watchdogTimeout(watchdogTimeout), .cpuLockup(cpuLockup),
		.coreSystemResetRequest(coreSystemResetRequest), .supplyLevel(supplyLevel),
		.radioEnabled(radioEnabled), .waitIntSleep(waitIntSleep),
		.waitEventSleep(waitEventSleep), .irqPending(irqPending), .irqEnabled(irqEnabled)
	);

	// ----------------------------------------------------------------
	// bus master and helpers
	// ----------------------------------------------------------------
	task busXfer(input logic [11:0] a, input logic wr, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
	endtask : busXfer

	task busWrite(input logic [11:0] a, input logic [31:0] d);
		busXfer(a, 1'b1, d);
	endtask : busWrite

	// read data is taken at the edge that closes the data phase
	task chkReg(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		busXfer(a, 1'b0, 32'h0);
		v = hrdata;
		`CHK(v, e)
		`CHK(hresp, 1'b0)
	endtask : chkReg

	// registered outputs need a few edges to follow their inputs
	task settle;
		repeat (4) @(posedge mclk);
		#1;
	endtask : settle

	task waitSys(input logic v);
		int n;
		n = 0;
		while (sysReset !== v && n < 200) begin
			@(posedge mclk);
			n++;
		end
		`CHK(sysReset, v)
	endtask : waitSys

	task printVerdict;
		$display("compared %0d, mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : printVerdict

	// hang guard, well above the several hundred cycles the sequence needs
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			printVerdict();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (20) @(posedge mclk);
		`CHK(sysReset, 1'b1)
		i_spm_wake_source_model.setSupply(9'h12c);
		waitSys(1'b0);
		chkReg(ADDR_MODE_STAT, 32'h00000001);
		chkReg(ADDR_RAM_CTRL, RAM_CTRL_RST);
		chkReg(ADDR_CAUSE, 32'h0);
		chkReg(12'h0f0, 32'h0);
		// sleep sub-modes and wake from cpu sleep
		i_spm_wake_source_model.setCpu(1'b1, 1'b0, 32'h8, 32'h0, 1'b0);
		busWrite(ADDR_FIXED_LAT, 32'h1);
		settle();
		`CHK(forcedBaseOn, 1'b1)
		`CHK(cpuWake, 1'b0)
		chkReg(ADDR_MODE_STAT, 32'h00000011);
		i_spm_wake_source_model.setCpu(1'b1, 1'b0, 32'h8, 32'h8, 1'b0);
		settle();
		`CHK(cpuWake, 1'b1)
		i_spm_wake_source_model.setCpu(1'b0, 1'b1, 32'h8, 32'h0, 1'b0);
		busWrite(ADDR_ECO_SLEEP, 32'h1);
		settle();
		`CHK(cpuWake, 1'b1)
		`CHK(forcedBaseOn, 1'b0)
		i_spm_wake_source_model.setCpu(1'b0, 1'b0, 32'h0, 32'h0, 1'b0);
		// buck converter only runs with the radio
		busWrite(ADDR_BUCK, 32'h1);
		settle();
		`CHK(buckConverterOn, 1'b0)
		i_spm_wake_source_model.setCpu(1'b0, 1'b0, 32'h0, 32'h0, 1'b1);
		settle();
		`CHK(buckConverterOn, 1'b1)
		i_spm_wake_source_model.setCpu(1'b0, 1'b0, 32'h0, 32'h0, 1'b0);
		busWrite(ADDR_BUCK, 32'h0);
		settle();
		`CHK(buckConverterOn, 1'b0)
		// every threshold code, hysteresis edges included
		for (int t = 0; t < 4; t++) begin
			busWrite(ADDR_WARN_CFG, {29'h0, t[1:0], 1'b1});
			i_spm_wake_source_model.setSupply(FAIL_LVL[t] - 9'h001);
			settle();
			`CHK(powerWarn, 1'b1)
			`CHK(flashWriteBlock, 1'b1)
			`CHK(sysReset, 1'b0)
			i_spm_wake_source_model.setSupply(FAIL_LVL[t] + HYST_LVL - 9'h001);
			settle();
			`CHK(powerWarn, 1'b1)
			i_spm_wake_source_model.setSupply(FAIL_LVL[t] + HYST_LVL);
			settle();
			`CHK(powerWarn, 1'b0)
		end
		chkReg(ADDR_WARN_EVT, 32'h1);
		busWrite(ADDR_WARN_EVT, 32'h0);
		chkReg(ADDR_WARN_EVT, 32'h0);
		i_spm_wake_source_model.setSupply(9'h12c);
		// ram blocks, block 0 retained
		busWrite(ADDR_RAM_CTRL, 32'h00010003);
		busWrite(ADDR_RAM_CTRL_U, 32'h00000001);
		settle();
		`CHK(ramPower, 4'h7)
		chkReg(ADDR_RAM_STAT, 32'h7);
		// system off, then wake by gpio, comparator and debug entry
		for (int k = 0; k < 3; k++) begin
			busWrite(ADDR_FIXED_LAT, 32'h1);
			busWrite(ADDR_SYS_OFF, 32'h1);
			settle();
			`CHK(ramPower, 4'h1)
			`CHK(peripheralsOn, 1'b0)
			`CHK(taskAbort, 1'b1)
			`CHK(coreDomainOn, 1'b0)
			`CHK(debugDomainsOn, 1'b0)
			i_spm_wake_source_model.setLine((k == 2) ? 3 : k, 1'b1);
			waitSys(1'b1);
			if (k < 2)
				i_spm_wake_source_model.setLine(k, 1'b0);
			waitSys(1'b0);
			chkReg(ADDR_CAUSE, 32'h1 << (16 + k));
			chkReg(ADDR_RAM_CTRL, 32'h00010003);
			chkReg(ADDR_MODE_STAT, (k == 2) ? 32'h41 : 32'h01);
			busWrite(ADDR_CAUSE, 32'h1 << (16 + k));
			chkReg(ADDR_CAUSE, 32'h0);
			`CHK(ramPower, 4'h7)
			`CHK(peripheralsOn, 1'b1)
			`CHK(taskAbort, 1'b0)
		end
		// debug mode: emulated off, pin ignored, wake keeps debug port
		busWrite(ADDR_SYS_OFF, 32'h1);
		settle();
		`CHK(debugDomainsOn, 1'b1)
		`CHK(coreDomainOn, 1'b1)
		chkReg(ADDR_MODE_STAT, 32'h44);
		i_spm_wake_source_model.setLine(2, 1'b1);
		repeat (10) @(posedge mclk);
		`CHK(sysReset, 1'b0)
		i_spm_wake_source_model.setLine(2, 1'b0);
		i_spm_wake_source_model.setLine(0, 1'b1);
		waitSys(1'b1);
		repeat (2) @(posedge mclk);
		`CHK(debugPortReset, 1'b0)
		i_spm_wake_source_model.setLine(0, 1'b0);
		waitSys(1'b0);
		chkReg(ADDR_CAUSE, 32'h00010000);
		busWrite(ADDR_CAUSE, CAUSE_MASK);
		busWrite(ADDR_RST_CFG, 32'h1);
		i_spm_wake_source_model.setLine(2, 1'b1);
		waitSys(1'b1);
		i_spm_wake_source_model.setLine(2, 1'b0);
		waitSys(1'b0);
		chkReg(ADDR_CAUSE, 32'h1);
		i_spm_wake_source_model.setLine(3, 1'b0);
		settle();
		// watchdog, lockup and soft reset; flags accumulate
		expC = 32'h1;
		for (int j = 0; j < 3; j++) begin
			i_spm_wake_source_model.pulseReq(j);
			waitSys(1'b1);
			repeat (2) @(posedge mclk);
			`CHK(debugPortReset, (j == 0))
			waitSys(1'b0);
			expC = expC | (32'h1 << cb[j]);
			chkReg(ADDR_CAUSE, expC);
		end
		// brown-out holds reset and clears every flag
		i_spm_wake_source_model.setSupply(BOR_LVL - 9'h001);
		settle();
		`CHK(sysReset, 1'b1)
		i_spm_wake_source_model.setSupply(9'h12c);
		waitSys(1'b0);
		chkReg(ADDR_CAUSE, 32'h0);
		printVerdict();
	end
endmodule : spm_power_reset_manager_tb
